// >>> erwb_top.sv
`timescale 1ns/100ps
module erwb_top import erwb_pkg::*; (
	// clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// serial command link
	input wire logic cs_n_in,
	input wire logic dc_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic busy_out,
	// image RAM port
	output logic ram_we_out,
	output logic ram_red_out,
	output logic [5:0] ram_x_out,
	output logic [8:0] ram_y_out,
	output logic [7:0] ram_wdata_out,
	input wire logic [7:0] ram_rdata_in,
	// waveform side
	output logic [2:0] border_drive_out,
	output logic [1:0] border_table_out,
	output logic [7:0] waveform_end_option_out,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out
);
	// whole module state
	typedef struct packed {
		logic cs_s1, cs_s2, dc_s1, dc_s2, sda_s1, sda_s2; // pin synchronisers
		logic scl_s1, scl_s2, scl_s3; // link clock sampled, plus edge history
		logic [2:0] bitcnt; // bits taken in current byte
		logic [7:0] rxsh; // incoming shift
		logic [7:0] txsh; // outgoing shift, msb on the pin
		logic [7:0] cmd; // last command code
		logic [2:0] idx; // parameter byte index
		erwb_mode_t mode;
		logic wr_red; // RAM write target
		logic [7:0] border;
		logic [7:0] end_opt;
		logic rd_sel;
		logic [5:0] xs, xe, xc;
		logic [8:0] ys, ye, yc;
		logic [7:0] fill_red_par, fill_bw_par;
		logic fill_red, p0, xpar, ypar; // fill target and pattern phase
		logic [5:0] fx;
		logic [8:0] fy, fys, h_last;
		logic [4:0] fxs, w_last;
		erwb_drive_t drive;
		logic [1:0] table_sel;
		logic ram_we, ram_red;
		logic [5:0] ram_x;
		logic [8:0] ram_y;
		logic [7:0] ram_wd;
		logic link_en; // software gate on the link
		logic wb_ack;
		logic [31:0] wb_dat;
	} erwb_state_t;

	erwb_state_t st; // registered state
	erwb_state_t nx; // next state
	logic scl_rise; // sampled link clock edges
	logic scl_fall;
	logic byte_done; // eighth bit of a byte taken
	logic [7:0] rx_byte; // completed byte
	logic wb_go; // bus request seen this cycle
	logic [14:0] stepped; // counters after one step

	// reset image of the state
	function automatic erwb_state_t rst_val();
		rst_val = '0;
		rst_val.cs_s1 = 1'b1;
		rst_val.cs_s2 = 1'b1;
		rst_val.mode = M_IDLE;
		rst_val.border = BORDER_RST;
		rst_val.end_opt = END_OPT_RST;
		rst_val.rd_sel = READ_SEL_RST;
		rst_val.xs = X_START_RST;
		rst_val.xe = X_END_RST;
		rst_val.xc = X_START_RST;
		rst_val.ys = Y_START_RST;
		rst_val.ye = Y_END_RST;
		rst_val.yc = Y_START_RST;
		rst_val.fill_red_par = FILL_RST;
		rst_val.fill_bw_par = FILL_RST;
		rst_val.drive = DRV_HIGH_Z;
		rst_val.link_en = CTRL_RST;
	endfunction : rst_val

	// counters advance one byte, wrapping inside the window
	function automatic logic [14:0] step_addr(input logic [5:0] x, input logic [8:0] y,
			input logic [5:0] x0, input logic [5:0] x1, input logic [8:0] y0, input logic [8:0] y1);
		logic [5:0] nxv;
		logic [8:0] nyv;
		nxv = x + 6'h01;
		nyv = y;
		if (x == x1) begin
			nxv = x0;
			nyv = (y == y1) ? y0 : y + 9'h001;
		end
		step_addr = {nyv, nxv};
	endfunction : step_addr

	// edges are found only on the second and third sampling stages
	assign scl_rise = st.scl_s2 & ~st.scl_s3;
	assign scl_fall = ~st.scl_s2 & st.scl_s3;
	assign byte_done = ~st.cs_s2 & st.link_en & scl_rise & (st.bitcnt == 3'h7);
	assign rx_byte = {st.rxsh[6:0], st.sda_s2};
	assign wb_go = wb_cyc_in & wb_stb_in & ~st.wb_ack;
	assign stepped = step_addr(st.xc, st.yc, st.xs, st.xe, st.ys, st.ye);

	// next-state logic
	always_comb begin
		nx = st;
		// two flops on every pin before use
		nx.cs_s1 = cs_n_in;
		nx.cs_s2 = st.cs_s1;
		nx.dc_s1 = dc_in;
		nx.dc_s2 = st.dc_s1;
		nx.sda_s1 = sda_in;
		nx.sda_s2 = st.sda_s1;
		nx.scl_s1 = scl_in;
		nx.scl_s2 = st.scl_s1;
		nx.scl_s3 = st.scl_s2;
		nx.ram_we = 1'b0;
		nx.ram_x = st.xc;
		nx.ram_y = st.yc;
		nx.ram_red = (st.mode == M_WRITE) ? st.wr_red : st.rd_sel;
		// bit assembly, msb first on rising link clock
		if (st.cs_s2 | ~st.link_en) begin
			nx.bitcnt = 3'h0;
		end else if (scl_rise) begin
			nx.rxsh = rx_byte;
			nx.bitcnt = st.bitcnt + 3'h1;
		end
		// readback shifts on the falling edge, except right after a reload
		if (scl_fall && st.mode == M_READ && !st.cs_s2 && st.bitcnt != 3'h0) begin
			nx.txsh = {st.txsh[6:0], 1'b0};
		end
		// bytes are refused while a fill runs
		if (byte_done && st.mode != M_FILL) begin
			if (!st.dc_s2) begin
				// a new command always ends a RAM write or read
				nx.cmd = rx_byte;
				nx.idx = 3'h0;
				nx.mode = M_IDLE;
				unique case (rx_byte)
					CMD_WRITE_BW, CMD_WRITE_RED: begin
						nx.mode = M_WRITE;
						nx.wr_red = (rx_byte == CMD_WRITE_RED);
					end
					CMD_READ_RAM: begin
						nx.mode = M_READ;
						nx.txsh = DUMMY_BYTE;
					end
					default: begin
						// no-operation and others: nothing more
					end
				endcase
			end else if (st.mode == M_READ) begin
				// byte out done: fetch at the counters, then step them
				nx.txsh = ram_rdata_in;
				{nx.yc, nx.xc} = stepped;
			end else if (st.mode == M_WRITE) begin
				nx.ram_we = 1'b1;
				nx.ram_wd = rx_byte;
				{nx.yc, nx.xc} = stepped;
			end else begin
				if (st.idx != 3'h7) begin
					nx.idx = st.idx + 3'h1;
				end
				unique case (st.cmd)
					CMD_BORDER: if (st.idx == 3'h0) nx.border = rx_byte;
					CMD_END_OPT: if (st.idx == 3'h0) nx.end_opt = rx_byte;
					CMD_READ_OPT: if (st.idx == 3'h0) nx.rd_sel = rx_byte[0];
					CMD_X_WIN: begin
						if (st.idx == 3'h0) nx.xs = rx_byte[5:0];
						if (st.idx == 3'h1) nx.xe = rx_byte[5:0];
					end
					CMD_Y_WIN: begin
						if (st.idx == 3'h0) nx.ys[7:0] = rx_byte;
						if (st.idx == 3'h1) nx.ys[8] = rx_byte[0];
						if (st.idx == 3'h2) nx.ye[7:0] = rx_byte;
						if (st.idx == 3'h3) nx.ye[8] = rx_byte[0];
					end
					CMD_X_COUNT: if (st.idx == 3'h0) nx.xc = rx_byte[5:0];
					CMD_Y_COUNT: begin
						if (st.idx == 3'h0) nx.yc[7:0] = rx_byte;
						if (st.idx == 3'h1) nx.yc[8] = rx_byte[0];
					end
					CMD_FILL_RED, CMD_FILL_BW: begin
						if (st.idx == 3'h0) begin
							if (st.cmd == CMD_FILL_RED) begin
								nx.fill_red_par = rx_byte;
							end else begin
								nx.fill_bw_par = rx_byte;
								nx.fill_bw_par[FILL_BW_UNUSED_BIT] = 1'b0;
							end
							// invalid height or width codes start nothing
							if (rx_byte[FILL_H_LSB+:3] != 3'h7 && rx_byte[FILL_W_LSB+:3] < 3'h6) begin
								nx.mode = M_FILL;
								nx.fill_red = (st.cmd == CMD_FILL_RED);
								nx.p0 = rx_byte[FILL_P0_BIT];
								nx.h_last = STEP_H[rx_byte[FILL_H_LSB+:3]] - 9'h001;
								nx.w_last = STEP_W[rx_byte[FILL_W_LSB+:3]] - 5'h01;
								nx.fx = 6'h00;
								nx.fy = 9'h000;
								nx.fxs = 5'h00;
								nx.fys = 9'h000;
								nx.xpar = 1'b0;
								nx.ypar = 1'b0;
							end
						end
					end
					default: begin
						// parameters of other commands are dropped
					end
				endcase
			end
		end
		// fill engine: one byte per clock over the whole RAM
		if (st.mode == M_FILL) begin
			nx.ram_we = 1'b1;
			nx.ram_red = st.fill_red;
			nx.ram_x = st.fx;
			nx.ram_y = st.fy;
			nx.ram_wd = {8{st.p0 ^ st.xpar ^ st.ypar}};
			if (st.fx == FILL_X_BYTES - 6'h01) begin
				nx.fx = 6'h00;
				nx.fxs = 5'h00;
				nx.xpar = 1'b0;
				if (st.fy == FILL_Y_ROWS - 9'h001) begin
					nx.mode = M_IDLE;
				end else begin
					nx.fy = st.fy + 9'h001;
				end
				if (st.fys == st.h_last) begin
					nx.fys = 9'h000;
					nx.ypar = ~st.ypar;
				end else begin
					nx.fys = st.fys + 9'h001;
				end
			end else begin
				nx.fx = st.fx + 6'h01;
				if (st.fxs == st.w_last) begin
					nx.fxs = 5'h00;
					nx.xpar = ~st.xpar;
				end else begin
					nx.fxs = st.fxs + 5'h01;
				end
			end
		end
		// border decode from the stored control byte
		nx.table_sel = nx.border[BORDER_LUT_LSB+:2];
		unique case (nx.border[BORDER_MODE_LSB+:2])
			2'b00: nx.drive = DRV_TABLE;
			2'b01: begin
				unique case (nx.border[BORDER_LEVEL_LSB+:2])
					2'b00: nx.drive = DRV_GROUND;
					2'b01: nx.drive = DRV_POS_ONE;
					2'b10: nx.drive = DRV_NEG;
					2'b11: nx.drive = DRV_POS_TWO;
				endcase
			end
			2'b10: nx.drive = DRV_COMMON;
			2'b11: nx.drive = DRV_HIGH_Z;
		endcase
		// wishbone: one wait-free answer, ack dropped the cycle after
		nx.wb_ack = wb_go;
		// a write lands only at the edge where the master sees ack and still holds the request
		if (wb_cyc_in && wb_stb_in && wb_we_in && st.wb_ack && wb_sel_in[0] && wb_adr_in == REG_CTRL) begin
			nx.link_en = wb_dat_in[0];
		end
		if (wb_go) begin
			nx.wb_dat = 32'h0000_0000;
			unique case (wb_adr_in)
				REG_BORDER: nx.wb_dat[7:0] = st.border;
				REG_END_OPT: nx.wb_dat[7:0] = st.end_opt;
				REG_X_WIN: nx.wb_dat[13:0] = {2'h0, st.xe, st.xs};
				REG_Y_WIN: nx.wb_dat[17:0] = {st.ye, st.ys};
				REG_COUNT: nx.wb_dat[14:0] = {st.yc, st.xc};
				REG_STATUS: nx.wb_dat[3:0] = {st.mode, st.rd_sel, st.mode == M_FILL};
				REG_CTRL: nx.wb_dat[0] = st.link_en;
				default: begin
					// unmapped: acked, reads zero
				end
			endcase
		end
	end

	// the one register stage
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			st <= rst_val();
		end else begin
			st <= nx;
		end
	end

	// outputs
	assign sda_out = st.txsh[7];
	assign sda_oe_out = (st.mode == M_READ) & ~st.cs_s2 & st.dc_s2;
	assign busy_out = (st.mode == M_FILL);
	assign ram_we_out = st.ram_we;
	assign ram_red_out = st.ram_red;
	assign ram_x_out = st.ram_x;
	assign ram_y_out = st.ram_y;
	assign ram_wdata_out = st.ram_wd;
	assign border_drive_out = st.drive;
	assign border_table_out = st.table_sel;
	assign waveform_end_option_out = st.end_opt;
	assign wb_dat_out = st.wb_dat;
	assign wb_ack_out = st.wb_ack;
endmodule : erwb_top

// >>> erwb_pkg.sv
// What this block does
// - fixed border level 00 ground 01 pos1 10 neg 11 pos2
// - transition border uses table zero to three
// - end option byte stored and driven out
// - read selector picks black/white or red RAM
// - X window start resets zero, six bits
// - X window end resets to 15 hex
// - Y window start nine bits, low then high
// - Y window end resets to 127 hex
// - red fill parameter, fills red RAM pattern
// - black/white fill, same layout, bit3 unused
// - bit7 is first step value, then alternates
// - step height and width decode, invalid codes refused
// - busy high while the fill runs; the last write comes out in the first cycle with busy low
// - X counter command loads six-bit counter
// - Y counter command loads nine-bit counter
// - readback opens with a dummy byte
package erwb_pkg;
	// command codes
	localparam logic [7:0] CMD_WRITE_BW = 8'h24;
	localparam logic [7:0] CMD_WRITE_RED = 8'h26;
	localparam logic [7:0] CMD_READ_RAM = 8'h27;
	localparam logic [7:0] CMD_BORDER = 8'h3C;
	localparam logic [7:0] CMD_END_OPT = 8'h3F;
	localparam logic [7:0] CMD_READ_OPT = 8'h41;
	localparam logic [7:0] CMD_X_WIN = 8'h44;
	localparam logic [7:0] CMD_Y_WIN = 8'h45;
	localparam logic [7:0] CMD_FILL_RED = 8'h46;
	localparam logic [7:0] CMD_FILL_BW = 8'h47;
	localparam logic [7:0] CMD_X_COUNT = 8'h4E;
	localparam logic [7:0] CMD_Y_COUNT = 8'h4F;
	localparam logic [7:0] CMD_NO_OP = 8'h7F;
	// reset values
	localparam logic [7:0] BORDER_RST = 8'hC0;
	localparam logic [7:0] END_OPT_RST = 8'h22;
	localparam logic READ_SEL_RST = 1'b0;
	localparam logic [5:0] X_START_RST = 6'h00;
	localparam logic [5:0] X_END_RST = 6'h15;
	localparam logic [8:0] Y_START_RST = 9'h000;
	localparam logic [8:0] Y_END_RST = 9'h127;
	localparam logic [7:0] FILL_RST = 8'h00;
	localparam logic [7:0] DUMMY_BYTE = 8'h00;
	localparam logic CTRL_RST = 1'b1;
	// field positions
	localparam int BORDER_MODE_LSB = 6;
	localparam int BORDER_LEVEL_LSB = 4;
	localparam int BORDER_LUT_LSB = 0;
	localparam int FILL_P0_BIT = 7;
	localparam int FILL_H_LSB = 4;
	localparam int FILL_W_LSB = 0;
	localparam int FILL_BW_UNUSED_BIT = 3;
	// fill geometry: whole RAM, bytes across and rows down
	localparam logic [5:0] FILL_X_BYTES = 6'h16;
	localparam logic [8:0] FILL_Y_ROWS = 9'h128;
	// step height in rows and step width in bytes (8 pixels each)
	localparam logic [8:0] STEP_H [0:6] = '{9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100, 9'h128};
	localparam logic [4:0] STEP_W [0:5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h16};
	// register offsets
	localparam logic [7:0] REG_BORDER = 8'h00;
	localparam logic [7:0] REG_END_OPT = 8'h04;
	localparam logic [7:0] REG_X_WIN = 8'h08;
	localparam logic [7:0] REG_Y_WIN = 8'h0C;
	localparam logic [7:0] REG_COUNT = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_CTRL = 8'h18;
	// border drive codes
	typedef enum logic [2:0] {
		DRV_GROUND = 3'b000,
		DRV_POS_ONE = 3'b001,
		DRV_NEG = 3'b010,
		DRV_POS_TWO = 3'b011,
		DRV_COMMON = 3'b100,
		DRV_HIGH_Z = 3'b101,
		DRV_TABLE = 3'b110
	} erwb_drive_t;
	// command engine modes
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_WRITE = 2'b01,
		M_READ = 2'b10,
		M_FILL = 2'b11
	} erwb_mode_t;
endpackage : erwb_pkg

// >>> erwb_host_model.sv
`timescale 1ns/100ps
module erwb_host_model (
	// clock
	input wire logic mclk_in,
	// link lines
	output logic cs_n_out,
	output logic dc_out,
	output logic scl_out,
	output logic sda_out,
	input wire logic sda_in
);
	// idle: deselected, clock parked low
	initial begin
		cs_n_out = 1'b1;
		dc_out = 1'b0;
		scl_out = 1'b0;
		sda_out = 1'b0;
	end
	// one byte msb first; data moves with the falling clock, rx takes the wire on each rise
	task automatic xfer(input logic dc, input logic [7:0] tx, output logic [7:0] rx);
		@(posedge mclk_in);
		cs_n_out <= 1'b0;
		dc_out <= dc;
		for (int i = 7; i >= 0; i--) begin
			// 8 + 8 system clocks: the whole-cycle period nearest to 125 ns
			sda_out <= tx[i];
			scl_out <= 1'b0;
			repeat (8) @(posedge mclk_in);
			scl_out <= 1'b1;
			rx[i] = sda_in;
			repeat (8) @(posedge mclk_in);
		end
		scl_out <= 1'b0;
		repeat (8) @(posedge mclk_in);
		cs_n_out <= 1'b1;
		// released line shows the inverse, not a stale bit
		sda_out <= ~tx[0];
	endtask : xfer
endmodule : erwb_host_model

// >>> erwb_top_monitor.sv
`timescale 1ns/100ps
module erwb_top_monitor import erwb_pkg::*; (
	// clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// bus
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	// engine
	input wire logic busy_out,
	input wire logic sda_oe_out,
	input wire logic ram_we_out,
	input wire logic [5:0] ram_x_out,
	input wire logic [8:0] ram_y_out,
	input wire logic [7:0] ram_wdata_out,
	input wire logic [7:0] waveform_end_option_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	// request taken, then one-cycle answer
	sequence s_take;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence s_answer;
		wb_ack_out ##1 !wb_ack_out;
	endsequence
	// one fill write
	sequence s_fill;
		busy_out && ram_we_out;
	endsequence
	a_wb_answer: assert property (s_take |=> s_answer)
		else $error("bus answer wrong");
	a_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in > 8'h18 |-> wb_dat_out == 32'h0)
		else $error("unmapped read not zero");
	a_reset_state: assert property ($fell(sys_rst_in) |-> !busy_out && waveform_end_option_out == END_OPT_RST)
		else $error("state after reset wrong");
	a_fill_level: assert property (s_fill |-> ram_wdata_out inside {8'h00, 8'hFF})
		else $error("fill byte mixed");
	a_fill_bounds: assert property (s_fill |-> ram_x_out < FILL_X_BYTES && ram_y_out < FILL_Y_ROWS)
		else $error("fill address out of RAM");
	a_fill_step: assert property (s_fill ##0 ram_x_out != 6'h15 |=> ram_we_out && ram_x_out == $past(ram_x_out) + 6'h01)
		else $error("fill column skipped");
	a_fill_row: assert property (s_fill ##0 ram_x_out == 6'h15 && ram_y_out != 9'h127 |=>
		ram_we_out && ram_x_out == 6'h00 && ram_y_out == $past(ram_y_out) + 9'h001) else $error("fill row skipped");
	// readback never writes; the trade is that busy also stays low while reading
	a_read_quiet: assert property (sda_oe_out |-> !ram_we_out && !busy_out)
		else $error("write during readback");
endmodule : erwb_top_monitor
bind erwb_top erwb_top_monitor u_mon (.mclk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
	.wb_dat_out, .wb_ack_out, .busy_out, .sda_oe_out, .ram_we_out, .ram_x_out, .ram_y_out, .ram_wdata_out,
	.waveform_end_option_out);

// >>> erwb_top_tb.sv
`timescale 1ns/100ps
module erwb_top_tb import erwb_pkg::*;;
	// clock, reset, link
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic cs_n, dc, scl, sda_h, sda_d, sda_oe, busy, ram_we, ram_red, wb_ack, fill_red, fill_p0;
	logic fill_on = 1'b0;
	logic [5:0] ram_x;
	logic [8:0] ram_y;
	logic [7:0] ram_wd, waveform_end_option, rx;
	logic [7:0] ram_rd = 8'h00;
	logic [2:0] bdrv;
	logic [1:0] btab;
	// bus master
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dw = 32'h0, wb_dr, rd;
	logic [22:0] wq[$];
	int bad_count = 0, check_count = 0, wcount, fill_h, fill_w, k;
	// link bytes, bit 8 = data: windows, counters, writes ended by no-op
	logic [8:0] prog[19] = '{9'h044, 9'h103, 9'h105, 9'h045, 9'h101, 9'h101, 9'h102, 9'h101, 9'h04E, 9'h104,
		9'h04F, 9'h101, 9'h101, 9'h024, 9'h1A1, 9'h1A2, 9'h1A3, 9'h07F, 9'h1FF};
	// wire level: block wins while it drives
	wire logic sda_w = sda_oe ? sda_d : sda_h;
	initial begin
		forever #4 mclk_in = ~mclk_in;
	end
	erwb_top u_dut (.mclk_in, .sys_rst_in, .cs_n_in(cs_n), .dc_in(dc), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_d), .sda_oe_out(sda_oe), .busy_out(busy), .ram_we_out(ram_we), .ram_red_out(ram_red),
		.ram_x_out(ram_x), .ram_y_out(ram_y), .ram_wdata_out(ram_wd), .ram_rdata_in(ram_rd),
		.border_drive_out(bdrv), .border_table_out(btab), .waveform_end_option_out(waveform_end_option), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hF), .wb_dat_in(wb_dw),
		.wb_dat_out(wb_dr), .wb_ack_out(wb_ack));
	erwb_host_model u_host (.mclk_in, .cs_n_out(cs_n), .dc_out(dc), .scl_out(scl), .sda_out(sda_h), .sda_in(sda_w));
	// RAM data made from address; writes checked or queued
	always @(posedge mclk_in) begin
		ram_rd <= {ram_red, ram_y[0], ram_x};
		if (ram_we === 1'b1 && fill_on) begin
			wcount++;
			check("fill byte", 32'(ram_wd), 32'({8{fill_p0 ^ ((ram_x / fill_w) % 2 == 1) ^ ((ram_y / fill_h) % 2 == 1)}}));
			check("fill ram", 32'(ram_red), 32'(fill_red));
		end else if (ram_we === 1'b1) begin
			wq.push_back({ram_x, ram_y, ram_wd});
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	// classic single cycle, held until ack
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk_in);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dw} <= {2'b11, we, adr, wd};
		do begin
			@(posedge mclk_in);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		rd = wb_dr;
		{wb_cyc, wb_stb} <= 2'b00;
		if (n >= 50) begin
			bad_count++;
			close_out();
		end
	endtask : wb
	task automatic rreg(input string what, input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check(what, rd, exp);
	endtask : rreg
	task automatic snd(input logic d, input logic [7:0] b);
		u_host.xfer(d, b, rx);
	endtask : snd
	// fill run with step sizes in rows and bytes, n writes expected
	task automatic fill(input logic [7:0] c, input logic [7:0] p, input int h, input int w, input int n);
		fill_red = (c == CMD_FILL_RED);
		fill_p0 = p[7];
		fill_h = h;
		fill_w = w;
		wcount = 0;
		fill_on <= 1'b1;
		snd(1'b0, c);
		snd(1'b1, p);
		k = 0;
		while (busy !== 1'b0 && k < 7000) begin
			@(posedge mclk_in);
			k++;
		end
		// the last write is counted at this edge, so close the window after it
		fill_on <= 1'b0;
		@(posedge mclk_in);
		check("fill writes", wcount, n);
		check("busy span", 32'(k > 6000), 32'(n > 0));
		if (k >= 7000) begin
			bad_count++;
			close_out();
		end
	endtask : fill
	// main sequence
	initial begin
		repeat (5) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		rreg("border", REG_BORDER, 32'hC0);
		rreg("x window", REG_X_WIN, 32'h540);
		rreg("y window", REG_Y_WIN, 32'h24E00);
		rreg("counters", REG_COUNT, 32'h0);
		rreg("status", REG_STATUS, 32'h0);
		rreg("unmapped", 8'h40, 32'h0);
		wb(1'b1, REG_X_WIN, 32'hFFF);
		rreg("x window kept", REG_X_WIN, 32'h540);
		for (int i = 0; i < 4; i++) begin
			snd(1'b0, CMD_BORDER);
			snd(1'b1, 8'h40 | 8'(i << 4));
			check("fixed level", 32'(bdrv), i);
			snd(1'b0, CMD_BORDER);
			snd(1'b1, 8'(i));
			check("table mode", 32'(bdrv), 32'(DRV_TABLE));
			check("table", 32'(btab), i);
		end
		snd(1'b0, CMD_END_OPT);
		snd(1'b1, 8'h5A);
		check("end option", 32'(waveform_end_option), 32'h5A);
		// link gate off: a whole command and parameter must be ignored
		wb(1'b1, REG_CTRL, 32'h0);
		rreg("link off", REG_CTRL, 32'h0);
		snd(1'b0, CMD_END_OPT);
		snd(1'b1, 8'h11);
		check("link gated", 32'(waveform_end_option), 32'h5A);
		wb(1'b1, REG_CTRL, 32'h1);
		rreg("link on", REG_CTRL, 32'h1);
		foreach (prog[i]) snd(prog[i][8], prog[i][7:0]);
		rreg("x window", REG_X_WIN, 32'h143);
		rreg("y window", REG_Y_WIN, 32'h20501);
		rreg("counters", REG_COUNT, 32'h4084);
		check("writes", wq.size(), 3);
		check("write 0", 32'(wq[0]), 32'({6'h04, 9'h101, 8'hA1}));
		check("write 1", 32'(wq[1]), 32'({6'h05, 9'h101, 8'hA2}));
		check("write 2", 32'(wq[2]), 32'({6'h03, 9'h102, 8'hA3}));
		snd(1'b0, CMD_READ_OPT);
		snd(1'b1, 8'h01);
		rreg("read select", REG_STATUS, 32'h2);
		snd(1'b0, CMD_READ_RAM);
		snd(1'b1, 8'h00);
		check("dummy", 32'(rx), 32'(DUMMY_BYTE));
		snd(1'b1, 8'h00);
		check("red data", 32'(rx), 32'h84);
		fill(CMD_FILL_BW, 8'h88, 8, 1, 6512);
		fill(CMD_FILL_RED, 8'h4A, 128, 4, 6512);
		fill(CMD_FILL_BW, 8'h70, 8, 1, 0);
		fill(CMD_FILL_RED, 8'h06, 8, 1, 0);
		close_out();
	end
endmodule : erwb_top_tb
